// File: common/flm_pkg.sv
package flm_pkg;
	// clock and tone rates
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned TONE_HZ = 1000000;
	localparam int unsigned TONE_PERIOD_CYC = CLK_HZ / TONE_HZ;
	localparam int unsigned TONE_HIGH_CYC = TONE_PERIOD_CYC / 2;
	// detector windows, least times, rounded up to whole cycles
	localparam int unsigned ACT_WINDOW_NS = 300;
	localparam int unsigned LIGHT_WINDOW_NS = 2000;
	localparam int unsigned ACT_WINDOW_CYC =
		(ACT_WINDOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned LIGHT_WINDOW_CYC =
		(LIGHT_WINDOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned CNT_W = 12;
	// test-mode pin patterns
	localparam logic [2:0] TEST_MODE_RESET = 3'h0;
	localparam logic [2:0] TEST_MODE_RUN_DEFAULT = 3'h7;
	// reset values
	localparam logic [CNT_W-1:0] CNT_RST = 12'h000;

	typedef struct packed
	{
		logic good_light;
		logic tx_active;
	} flm_status_t;
endpackage

// File: rtl/flm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module flm_monitor #(
	parameter logic [2:0] TEST_MODE_RUN = flm_pkg::TEST_MODE_RUN_DEFAULT
)
(
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic TP_TX_I,
	input wire logic FIBER_RX_I,
	output logic FIBER_TX_O,
	output logic GOOD_LIGHT_INDICATOR_O,
	output logic TX_ACTIVE_O,
	output logic TEST_MODE_PIN_0_O,
	output logic TEST_MODE_PIN_1_O,
	output logic TEST_MODE_PIN_2_O
);
	localparam logic [flm_pkg::CNT_W-1:0] TONE_LAST =
		flm_pkg::CNT_W'(flm_pkg::TONE_PERIOD_CYC - 1);
	localparam logic [flm_pkg::CNT_W-1:0] TONE_HIGH =
		flm_pkg::CNT_W'(flm_pkg::TONE_HIGH_CYC);
	localparam logic [flm_pkg::CNT_W-1:0] ACT_LOAD =
		flm_pkg::CNT_W'(flm_pkg::ACT_WINDOW_CYC);
	localparam logic [flm_pkg::CNT_W-1:0] LIGHT_LOAD =
		flm_pkg::CNT_W'(flm_pkg::LIGHT_WINDOW_CYC);

	// tone divider state
	logic [flm_pkg::CNT_W-1:0] tone_cnt_q;
	logic [flm_pkg::CNT_W-1:0] tone_cnt_d;
	logic tone;

	// transmit activity detector state
	logic tp_prev_q;
	logic tp_prev_d;
	logic [flm_pkg::CNT_W-1:0] act_cnt_q;
	logic [flm_pkg::CNT_W-1:0] act_cnt_d;
	logic tp_edge;
	logic act_alive;

	// receive light detector state
	// only edges count, so a fibre stuck at either level reads as dark
	logic rx_prev_q;
	logic rx_prev_d;
	logic [flm_pkg::CNT_W-1:0] light_cnt_q;
	logic [flm_pkg::CNT_W-1:0] light_cnt_d;
	logic rx_edge;
	logic light_alive;

	// output stage state
	// every pin leaves from a flip-flop, so no glitch reaches the board
	logic fiber_tx_q;
	logic fiber_tx_d;
	logic [2:0] test_mode_q;
	logic [2:0] test_mode_d;
	flm_pkg::flm_status_t status_q;
	flm_pkg::flm_status_t status_d;

	// tone divider
	// phase restarts at reset release; the far end only needs the rate
	always_comb
	begin
		// tone: 62 high, 63 low at 125 MHz keeps the period exact
		if (tone_cnt_q == TONE_LAST)
		begin
			tone_cnt_d = '0;
		end
		else
		begin
			tone_cnt_d = tone_cnt_q + 1'b1;
		end
		tone = (tone_cnt_q < TONE_HIGH);
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			tone_cnt_q <= flm_pkg::CNT_RST;
		end
		else
		begin
			tone_cnt_q <= tone_cnt_d;
		end
	end

	// transmit activity detector
	always_comb
	begin
		tp_prev_d = TP_TX_I;
		tp_edge = (TP_TX_I != tp_prev_q);
		// any edge retriggers the window, otherwise it drains
		if (tp_edge)
		begin
			act_cnt_d = ACT_LOAD;
		end
		else if (act_cnt_q != '0)
		begin
			act_cnt_d = act_cnt_q - 1'b1;
		end
		else
		begin
			act_cnt_d = act_cnt_q;
		end
		act_alive = (act_cnt_d != '0);
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			tp_prev_q <= 1'b0;
			act_cnt_q <= flm_pkg::CNT_RST;
		end
		else
		begin
			tp_prev_q <= tp_prev_d;
			act_cnt_q <= act_cnt_d;
		end
	end

	// receive light detector
	// light counts as lost after reset until the first edge arrives
	always_comb
	begin
		rx_prev_d = FIBER_RX_I;
		rx_edge = (FIBER_RX_I != rx_prev_q);
		if (rx_edge)
		begin
			light_cnt_d = LIGHT_LOAD;
		end
		else if (light_cnt_q != '0)
		begin
			light_cnt_d = light_cnt_q - 1'b1;
		end
		else
		begin
			light_cnt_d = light_cnt_q;
		end
		light_alive = (light_cnt_d != '0);
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			rx_prev_q <= 1'b0;
			light_cnt_q <= flm_pkg::CNT_RST;
		end
		else
		begin
			rx_prev_q <= rx_prev_d;
			light_cnt_q <= light_cnt_d;
		end
	end

	// output stage
	// one register stage: data leaves one cycle after it is sampled
	always_comb
	begin
		// window must exceed the tone half period, or idle reads as loss
		status_d.tx_active = act_alive;
		status_d.good_light = light_alive;
		if (act_alive)
		begin
			fiber_tx_d = TP_TX_I;
		end
		else
		begin
			fiber_tx_d = tone;
		end
		if (light_alive)
		begin
			test_mode_d = TEST_MODE_RUN;
		end
		else
		begin
			test_mode_d = flm_pkg::TEST_MODE_RESET;
		end
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RSTN_I)
		begin
			fiber_tx_q <= 1'b0;
			test_mode_q <= flm_pkg::TEST_MODE_RESET;
			status_q <= '0;
		end
		else
		begin
			fiber_tx_q <= fiber_tx_d;
			test_mode_q <= test_mode_d;
			status_q <= status_d;
		end
	end

	// released pattern is a parameter: the run levels are a board choice
	assign FIBER_TX_O = fiber_tx_q;
	assign GOOD_LIGHT_INDICATOR_O = status_q.good_light;
	assign TX_ACTIVE_O = status_q.tx_active;
	assign TEST_MODE_PIN_0_O = test_mode_q[0];
	assign TEST_MODE_PIN_1_O = test_mode_q[1];
	assign TEST_MODE_PIN_2_O = test_mode_q[2];
endmodule
`default_nettype wire

// File: sim/flm_fiber_model.sv
`timescale 1ns/1ps
`default_nettype none
module flm_fiber_model #(parameter int HALF = 63)
(
	input wire logic clk_i,
	input wire logic lit_i,
	output logic rx_o
);
int n = 0;
logic rx_q = 1'b0;
assign rx_o = rx_q;
// far end idle tone while lit; dark fibre gives a steady level
// half period of 63 keeps the tone just under 1 MHz
always @(negedge clk_i)
begin
	n = lit_i && n < HALF - 1 ? n + 1 : 0;
	if (lit_i && n == 0)
		rx_q <= !rx_q;
end
endmodule
`default_nettype wire

// File: sim/flm_monitor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module flm_chk
(
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic TP_TX_I,
	input wire logic FIBER_RX_I,
	input wire logic FIBER_TX_O,
	input wire logic GOOD_LIGHT_INDICATOR_O,
	input wire logic TX_ACTIVE_O,
	input wire logic TEST_MODE_PIN_0_O,
	input wire logic TEST_MODE_PIN_1_O,
	input wire logic TEST_MODE_PIN_2_O
);
	logic tp_q;
	logic rx_q;
	logic [7:0] ta_q;
	logic [7:0] ra_q;
	logic [2:0] pins;
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	assign pins = {TEST_MODE_PIN_2_O, TEST_MODE_PIN_1_O, TEST_MODE_PIN_0_O};
	// cycles since last input edge, saturating so idle stays idle
	always_ff @(posedge SYS_CLK_I)
	begin
		tp_q <= TP_TX_I;
		rx_q <= FIBER_RX_I;
		if (!RSTN_I)
		begin
			ta_q <= 8'hFF;
			ra_q <= 8'hFF;
		end
		else
		begin
			if (TP_TX_I != tp_q)
				ta_q <= 8'h00;
			else
				ta_q <= ta_q + 8'(ta_q != 8'hFF);
			if (FIBER_RX_I != rx_q)
				ra_q <= 8'h00;
			else
				ra_q <= ra_q + 8'(ra_q != 8'hFF);
		end
	end
	tone_half_a: assert property ($rose(FIBER_TX_O) && ta_q > 8'h28 |->
		##61 (FIBER_TX_O || TX_ACTIVE_O) ##1 (!FIBER_TX_O || TX_ACTIVE_O))
		else $error("tone high time wrong");
	act_seen_a: assert property (ta_q < 8'h24 |-> TX_ACTIVE_O)
		else $error("activity missed");
	act_drop_a: assert property (ta_q > 8'h26 |-> !TX_ACTIVE_O)
		else $error("activity held too long");
	tx_route_a: assert property (TX_ACTIVE_O |->
		FIBER_TX_O == $past(TP_TX_I))
		else $error("data not routed");
	light_hold_a: assert property (ra_q < 8'hF8 |->
		GOOD_LIGHT_INDICATOR_O)
		else $error("light dropped early");
	light_drop_a: assert property (ra_q > 8'hFA |->
		!GOOD_LIGHT_INDICATOR_O)
		else $error("light kept");
	test_pins_a: assert property (pins ==
		(GOOD_LIGHT_INDICATOR_O ? 3'h7 : 3'h0))
		else $error("pins wrong");
	cover property ($fell(GOOD_LIGHT_INDICATOR_O));
	cover property ($rose(GOOD_LIGHT_INDICATOR_O));
	cover property ($fell(TX_ACTIVE_O));
endmodule
bind flm_monitor flm_chk i_flm_chk(.*);
`default_nettype wire

// File: sim/flm_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flm_monitor_tb_top;
typedef struct packed {logic lit; logic [15:0] cyc; logic [7:0] exp;} flm_row_t;
logic clk = 1'b0, rstn = 1'b0, tp = 1'b0, lit = 1'b0, ftx, good, act, p0, p1, p2, rx;
int err_count = 0, comparisons = 0, k, n;
// fourth row, dark, stops just short of the light window; the fifth runs past it
flm_row_t rows[5] = '{'{1'b1, 16'h012C, 8'h0F}, '{1'b0, 16'h0140, 8'h00},
	'{1'b1, 16'h0082, 8'h0F}, '{1'b0, 16'h00F0, 8'h0F},
	'{1'b0, 16'h0014, 8'h00}};
always #4 clk = ~clk;
flm_monitor i_flm_monitor(.SYS_CLK_I(clk), .RSTN_I(rstn), .TP_TX_I(tp),
	.FIBER_RX_I(rx), .FIBER_TX_O(ftx), .GOOD_LIGHT_INDICATOR_O(good),
	.TX_ACTIVE_O(act), .TEST_MODE_PIN_0_O(p0), .TEST_MODE_PIN_1_O(p1),
	.TEST_MODE_PIN_2_O(p2));
flm_fiber_model i_flm_fiber_model(.clk_i(clk), .lit_i(lit), .rx_o(rx));
task automatic chk(input logic [7:0] s, e);
	comparisons++;
	if (s !== e)
	begin
		err_count++;
		$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
	end
endtask
task automatic end_of_test;
	$display("%0d compares, %0d mismatches", comparisons, err_count);
	if (err_count == 0 && comparisons > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
task automatic cyc(input int c);
	repeat (c) @(negedge clk);
endtask
task automatic run(input logic v, output int c);
	for (c = 0; ftx === v && c < 200; c++)
		cyc(1);
endtask
// about ten times the expected run
initial
begin
	#100000;
	err_count++;
	end_of_test();
end
initial
begin
	cyc(12);
	chk({2'h0, good, p2, p1, p0, act, ftx}, 8'h00);
	rstn = 1'b1;
	$display("reset done");
	for (k = 0; k < 5; k++)
	begin
		lit = rows[k].lit;
		cyc(rows[k].cyc);
		chk({4'h0, good, p2, p1, p0}, rows[k].exp);
	end
	$display("rows done");
	for (k = 0; k < 20; k++)
	begin
		tp = !tp;
		cyc(2);
		chk({6'h0, act, ftx}, {7'h1, tp});
	end
	cyc(30);
	chk({7'h0, act}, 8'h1);
	cyc(10);
	chk({7'h0, act}, 8'h0);
	$display("activity done");
	run(1'b1, n);
	run(1'b0, n);
	run(1'b1, n);
	chk(8'(n), 8'h3E);
	run(1'b0, n);
	chk(8'(n), 8'h3F);
	$display("tone done");
	rstn = 1'b0;
	cyc(2);
	chk({2'h0, good, p2, p1, p0, act, ftx}, 8'h00);
	rstn = 1'b1;
	cyc(1);
	chk({4'h0, good, p2, p1, p0}, 8'h00);
	$display("reset again done");
	end_of_test();
end
endmodule
`default_nettype wire
